// ### verilog/bpcs_pkg.sv
// package: register map, field layout and carriers of the primary command/status bank
package bpcs_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          IDX_W        = 6;
  localparam int          REG_W        = 16;
  localparam int          EVT_N        = 3;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0]  CMD_IDX      = 6'h04;
  localparam logic [5:0]  STS_IDX      = 6'h06;
  localparam logic [5:0]  IRQ_STS_IDX  = 6'h08;
  localparam logic [5:0]  IRQ_MSK_IDX  = 6'h09;

  // ****************************************
  // command fields
  // ****************************************
  localparam int          CMD_IO_EN    = 0;
  localparam int          CMD_MEM_EN   = 1;
  localparam int          CMD_MASTER_EN = 2;
  localparam int          CMD_SPECIAL  = 3;
  localparam int          CMD_WINV     = 4;
  localparam int          CMD_VGA      = 5;
  localparam int          CMD_PAR_RESP = 6;
  localparam int          CMD_WAIT_CTL = 7;
  localparam int          CMD_SERR_EN  = 8;
  localparam int          CMD_FAST_B2B = 9;
  localparam logic [15:0] CMD_WMASK    = 16'h0147;
  localparam logic [15:0] CMD_RESET    = 16'h0000;

  // ****************************************
  // status fields
  // ****************************************
  localparam int          STS_DATA_PAR = 8;
  localparam int          STS_SYS_ERR  = 14;
  localparam int          STS_PAR_ERR  = 15;
  localparam logic [15:0] STS_RO_ONES  = 16'h0030;
  localparam logic [15:0] STS_RESET    = 16'h0030;

  // ****************************************
  // interrupt status / mask layout
  // ****************************************
  localparam int          IRQ_PAR_ERR  = 0;
  localparam int          IRQ_SYS_ERR  = 1;
  localparam int          IRQ_DATA_PAR = 2;
  localparam logic [2:0]  IRQ_RESET    = 3'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic addr_parity_err;
    logic data_parity_err;
    logic ecc_err;
    logic cpl_err;
    logic serr_req;
  } bpcs_hub_evt_t;

  typedef struct packed {
    logic io_target_en;
    logic pci_target_en;
    logic hub_init_en;
    logic upstream_mem_en;
    logic write_invalidate_en;
    logic err_report;
    logic system_error_message_cycle;
  } bpcs_gate_t;

  localparam bpcs_gate_t GATE_RESET = '0;

endpackage : bpcs_pkg

// ### verilog/bpcs_sticky.sv
// module: vector of sticky flags, set by hardware, cleared by writing one
`timescale 1ns/1ns
module bpcs_sticky #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         ce,
  // set and clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic      [W-1:0] q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // set wins over a clear in the same cycle
  always_comb begin
    q_nxt = (q_r & ~clr) | set;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : bpcs_sticky

// ### verilog/bpcs_regs.sv
// module: primary command/status register bank with avalon-mm slave and hub gating
//
// Operation
// - fast back-to-back enable reads zero
// - command bit 8 gates system-error cycle
// - bits 7, 5, 3 read zero, ignore writes
// - parity response off: no error reporting
// - parity response on: report, set data-parity flag
// - write-invalidate enable zero, never generated
// - bus master off: no upstream memory
// - memory space off: ignore pci, no hub start
// - memory space on: forward pci cycles
// - io space enable gates io target response
// - status 15 sets on any hub error
// - status 14 sets on system-error cycle
// - status 8 sets on errored completion
// - status 5 reads one always
`timescale 1ns/1ns
module bpcs_regs
  import bpcs_pkg::*;
(
  // clock, reset, enable
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [DATA_W-1:0]   avs_readdata,
  output logic                     avs_waitrequest,
  // hub link events
  input  wire bpcs_hub_evt_t       hub_evt,
  // gates toward the datapath
  output bpcs_gate_t               gate,
  // interrupt
  output logic                     irq
);

  // ****************************************
  // bus handshake
  // ****************************************
  logic              wait_r;
  logic              wait_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              req;
  logic              take;
  logic              wr_take;
  logic [IDX_W-1:0]  idx;

  assign req     = avs_read | avs_write;
  assign take    = req & ~wait_r;
  assign wr_take = avs_write & ~wait_r;
  assign idx     = avs_address[ADDR_W-1:2];

  // waitrequest drops for one cycle, one cycle after a request appears
  always_comb begin
    wait_nxt = 1'b1;
    if (req && wait_r) begin
      wait_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else if (ce) begin
      wait_r <= wait_nxt;
    end
  end

  // ****************************************
  // byte lane write masks
  // ****************************************
  logic [REG_W-1:0] lane_mask;
  logic [REG_W-1:0] wdata16;

  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata16   = avs_writedata[REG_W-1:0];

  // ****************************************
  // command register
  // ****************************************
  logic [REG_W-1:0] cmd_r;
  logic [REG_W-1:0] cmd_nxt;
  logic [REG_W-1:0] cmd_wmask;
  logic             cmd_wr;

  assign cmd_wr    = wr_take && (idx == CMD_IDX);
  assign cmd_wmask = lane_mask & CMD_WMASK;

  // only bits 8, 6, 2, 1, 0 are storage; the rest stay zero
  always_comb begin
    cmd_nxt = cmd_r;
    if (cmd_wr) begin
      cmd_nxt = (cmd_r & ~cmd_wmask)
              | (wdata16 & cmd_wmask);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_r <= CMD_RESET;
    end else if (ce) begin
      cmd_r <= cmd_nxt;
    end
  end

  // ****************************************
  // hub link event qualification
  // ****************************************
  logic par_resp;
  logic serr_en;
  logic any_err;
  logic data_par_evt;
  logic serr_evt;
  logic report_evt;

  assign par_resp     = cmd_r[CMD_PAR_RESP];
  assign serr_en      = cmd_r[CMD_SERR_EN];
  assign any_err      = hub_evt.addr_parity_err | hub_evt.data_parity_err
                      | hub_evt.ecc_err | hub_evt.cpl_err;
  assign report_evt   = par_resp & any_err;
  assign data_par_evt = par_resp & (hub_evt.data_parity_err | hub_evt.ecc_err
                      | hub_evt.cpl_err);
  assign serr_evt     = serr_en & hub_evt.serr_req;

  // ****************************************
  // primary status flags
  // ****************************************
  logic [EVT_N-1:0] sts_set;
  logic [EVT_N-1:0] sts_clr;
  logic [EVT_N-1:0] sts_q;
  logic             sts_wr;
  logic [REG_W-1:0] sts_w1c;

  assign sts_wr  = wr_take && (idx == STS_IDX);
  assign sts_w1c = sts_wr ? (wdata16 & lane_mask) : '0;

  always_comb begin
    sts_set          = '0;
    sts_set[IRQ_PAR_ERR]  = any_err;
    sts_set[IRQ_SYS_ERR]  = serr_evt;
    sts_set[IRQ_DATA_PAR] = data_par_evt;
    sts_clr               = '0;
    sts_clr[IRQ_PAR_ERR]  = sts_w1c[STS_PAR_ERR];
    sts_clr[IRQ_SYS_ERR]  = sts_w1c[STS_SYS_ERR];
    sts_clr[IRQ_DATA_PAR] = sts_w1c[STS_DATA_PAR];
  end

  bpcs_sticky #(
    .W       (EVT_N)
  ) u_sts (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .set     (sts_set),
    .clr     (sts_clr),
    .q       (sts_q)
  );

  logic [REG_W-1:0] sts_view;

  always_comb begin
    sts_view          = STS_RO_ONES;
    sts_view[STS_PAR_ERR]  = sts_q[IRQ_PAR_ERR];
    sts_view[STS_SYS_ERR]  = sts_q[IRQ_SYS_ERR];
    sts_view[STS_DATA_PAR] = sts_q[IRQ_DATA_PAR];
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  logic [EVT_N-1:0] irq_clr;
  logic [EVT_N-1:0] irq_q;
  logic [EVT_N-1:0] msk_r;
  logic [EVT_N-1:0] msk_nxt;

  assign irq_clr = (wr_take && (idx == IRQ_STS_IDX) && avs_byteenable[0])
                 ? avs_writedata[EVT_N-1:0] : '0;

  bpcs_sticky #(
    .W       (EVT_N)
  ) u_irq (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .set     (sts_set),
    .clr     (irq_clr),
    .q       (irq_q)
  );

  always_comb begin
    msk_nxt = msk_r;
    if (wr_take && (idx == IRQ_MSK_IDX) && avs_byteenable[0]) begin
      msk_nxt = avs_writedata[EVT_N-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      msk_r <= IRQ_RESET;
    end else if (ce) begin
      msk_r <= msk_nxt;
    end
  end

  logic irq_r;
  logic irq_nxt;

  always_comb begin
    irq_nxt = |(irq_q & msk_r);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= irq_nxt;
    end
  end

  // ****************************************
  // register views
  // ****************************************
  logic [DATA_W-1:0] cmd_word;
  logic [DATA_W-1:0] sts_word;
  logic [DATA_W-1:0] irq_word;
  logic [DATA_W-1:0] msk_word;

  // upper bits of every word read zero
  always_comb begin
    cmd_word            = '0;
    cmd_word[REG_W-1:0] = cmd_r;
    sts_word            = '0;
    sts_word[REG_W-1:0] = sts_view;
    irq_word            = '0;
    irq_word[EVT_N-1:0] = irq_q;
    msk_word            = '0;
    msk_word[EVT_N-1:0] = msk_r;
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    rdata_nxt = rdata_r;
    if (avs_read && wait_r) begin
      unique case (idx)
        CMD_IDX:     rdata_nxt = cmd_word;
        STS_IDX:     rdata_nxt = sts_word;
        IRQ_STS_IDX: rdata_nxt = irq_word;
        IRQ_MSK_IDX: rdata_nxt = msk_word;
        default:     rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // datapath gates
  // ****************************************
  bpcs_gate_t gate_r;
  bpcs_gate_t gate_nxt;

  always_comb begin
    gate_nxt                            = GATE_RESET;
    gate_nxt.io_target_en               = cmd_r[CMD_IO_EN];
    gate_nxt.pci_target_en              = cmd_r[CMD_MEM_EN];
    gate_nxt.hub_init_en                = cmd_r[CMD_MEM_EN];
    gate_nxt.upstream_mem_en            = cmd_r[CMD_MEM_EN] & cmd_r[CMD_MASTER_EN];
    gate_nxt.write_invalidate_en        = 1'b0;
    gate_nxt.err_report                 = report_evt;
    gate_nxt.system_error_message_cycle = serr_evt;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gate_r <= GATE_RESET;
    end else if (ce) begin
      gate_r <= gate_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;
  assign gate            = gate_r;
  assign irq             = irq_r;

endmodule : bpcs_regs

// ### test/bpcs_regs_checker.sv
// checker: bus handshake and gate relations of the primary command/status bank
`timescale 1ns/1ns
module bpcs_regs_checker
  import bpcs_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              ce,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic              avs_waitrequest,
  // hub side
  input wire bpcs_hub_evt_t     hub_evt,
  input wire bpcs_gate_t        gate
);
  // ****************
  // command shadow
  // ****************
  logic        acc;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic [1:0]  age_r;
  logic [1:0]  age_nxt;
  assign acc = avs_write && !avs_waitrequest && ce && avs_address[7:2] == CMD_IDX;
  always_comb begin
    sh_nxt = sh_r;
    age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
    if (acc) begin
      if (avs_byteenable[0]) sh_nxt[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1]) sh_nxt[15:8] = avs_writedata[15:8];
      age_nxt = 2'h0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sh_r <= CMD_RESET;
      age_r <= 2'h3;
    end else if (ce) begin
      sh_r <= sh_nxt;
      age_r <= age_nxt;
    end
  end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_err;
    age_r[1] && sh_r[6] && (|hub_evt[4:1]);
  endsequence
  sequence s_serr;
    age_r[1] && sh_r[8] && hub_evt.serr_req;
  endsequence
  AST_WAIT_ANS: assert property (ce && (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered next cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_NO_WINV: assert property (!gate.write_invalidate_en)
    else $error("write invalidate enabled");
  AST_IO_GATE: assert property (age_r[1] |-> gate.io_target_en == sh_r[0])
    else $error("io target gate differs from command");
  AST_MEM_GATE: assert property (age_r[1] |-> gate.pci_target_en == sh_r[1]
    && gate.hub_init_en == sh_r[1]) else $error("memory gate differs from command");
  AST_MASTER: assert property (age_r[1] |-> gate.upstream_mem_en == (sh_r[1] && sh_r[2]))
    else $error("upstream gate differs from command");
  AST_ERR_ON: assert property (s_err |=> gate.err_report)
    else $error("hub error not reported");
  AST_ERR_CAUSE: assert property (gate.err_report
    |-> $past(sh_r[6]) && $past(|hub_evt[4:1])) else $error("error reported without enabled cause");
  AST_SERR_ON: assert property (s_serr |=> gate.system_error_message_cycle)
    else $error("system error cycle missing");
  AST_SERR_CAUSE: assert property (gate.system_error_message_cycle
    |-> $past(hub_evt.serr_req) && $past(sh_r[8])) else $error("unexpected system error cycle");
endmodule : bpcs_regs_checker

bind bpcs_regs bpcs_regs_checker i_bpcs_regs_checker (.clk_sys, .rst, .ce, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .hub_evt, .gate);

// ### test/bpcs_hub_model.sv
// hub link partner: emits one-cycle event pulses on request
`timescale 1ns/1ns
module bpcs_hub_model
  import bpcs_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // request from bench
  input  wire logic       fire,
  input  wire logic [4:0] kind,
  // events
  output bpcs_hub_evt_t   hub_evt
);
  always_ff @(posedge clk_sys) begin
    hub_evt <= fire ? bpcs_hub_evt_t'(kind) : '0;
  end
endmodule : bpcs_hub_model

// ### test/testbench.sv
// testbench: register bank against a hub link event model
`timescale 1ns/1ns
module testbench
  import bpcs_pkg::*;
;
  logic          clk_sys = 1'b0;
  logic          rst = 1'b1;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [7:0]    avs_address = 8'h00;
  logic [31:0]   avs_writedata = 32'h0;
  logic [3:0]    avs_byteenable = 4'hf;
  logic [3:0]    be = 4'hf;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic          irq;
  logic          fire = 1'b0;
  logic [4:0]    kind = 5'h00;
  bpcs_hub_evt_t hub_evt;
  logic [31:0]   rdq;
  logic [31:0]   seed = 32'h4d4c96b1;
  int            fails = 0;
  int            n_checks = 0;
  int            cyc = 0;

  bpcs_regs i_bpcs_regs (.clk_sys, .rst, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .hub_evt,
    .gate(), .irq);
  bpcs_hub_model i_bpcs_hub_model (.clk_sys, .fire, .kind, .hub_evt);

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] sts_exp(input logic [4:0] k, input logic [15:0] c);
    sts_exp = 16'h0030;
    if (|k[4:1]) sts_exp[15] = 1'b1;
    if (|k[3:1] && c[6]) sts_exp[8] = 1'b1;
    if (k[0] && c[8]) sts_exp[14] = 1'b1;
  endfunction : sts_exp
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rdq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask : rd
  task automatic ev(input logic [4:0] k);
    fire <= 1'b1;
    kind <= k;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : ev
  // ****************
  // sequence
  // ****************
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] d;
    logic [15:0] c;
    logic [15:0] e;
    logic [4:0]  k;
    logic [2:0]  m;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h10, 32'h0);
    rd(8'h18, 32'h30);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 32'hffffffff : seed;
      wr(8'h10, d);
      rd(8'h10, d & 32'h147);
    end
    wr(8'h10, 32'h147);
    be = 4'h1;
    wr(8'h10, 32'h0);
    be = 4'hf;
    rd(8'h10, 32'h100);
    for (int i = 0; i < 10; i++) begin
      c = (i < 5) ? 16'h0047 : 16'h0103;
      k = 5'h10 >> (i % 5);
      seed = lfsr(seed);
      m = seed[2:0];
      wr(8'h10, {16'h0, c});
      wr(8'h24, {29'h0, m});
      wr(8'h18, 32'hffff);
      wr(8'h20, 32'h7);
      rd(8'h40, 32'h0);
      chk(32'(irq), 32'h0);
      ev(k);
      e = sts_exp(k, c);
      rd(8'h18, {16'h0, e});
      rd(8'h20, {29'h0, e[8], e[14], e[15]});
      chk(32'(irq), 32'(|({e[8], e[14], e[15]} & m)));
      wr(8'h18, 32'h0);
      rd(8'h18, {16'h0, e});
      be = 4'h1;
      wr(8'h18, 32'hffff);
      be = 4'hf;
      rd(8'h18, {16'h0, e});
    end
    end_sim();
  end
endmodule : testbench
